// ### hdl/sbm_defs.svh
// Register offsets, fixed RAM locations, field positions and timing constants
// Contract
// - Offer word, selective and combined monitor modes
// - Word mode captures every word after start; code waits for a trigger if trigger enable and start-on are set
// - Store bus word, then its tag word
// - Tag holds channel, validity and gap
// - Word counter wraps at top of RAM
// - First word goes to area pointer address
// - Pointer locations are overwritten, never skipped
// - Host reads word counter via stack register
// - Trigger and interrupt share one compare word
// - Pattern interrupt only when its mask set
// - Pattern trigger needs enable plus start/stop
// - External trigger rising edge starts capture
// - Selective mode frames and filters messages itself
// - Combined mode skips own and broadcast address
// - Monitor stacks use pointers at fixed locations
// - Lookup word from table base, bit by subaddress
// - Lookup address upper bits fixed, RT address below
// - Zero bit ignores command, one stores message
// - Data, status and second command stored consecutively
// - Programmable command and data stack sizes
`ifndef SBM_DEFS_SVH
`define SBM_DEFS_SVH
`define SBM_OFS_CTRL 8'h00
`define SBM_OFS_TRIG 8'h04
`define SBM_OFS_MASK 8'h08
`define SBM_OFS_OWNRT 8'h0c
`define SBM_OFS_STKCFG 8'h10
`define SBM_OFS_GAPLIM 8'h14
`define SBM_OFS_STKADDR 8'h18
`define SBM_OFS_STATUS 8'h1c
`define SBM_CTRL_START 2
`define SBM_CTRL_TRIGEN 3
`define SBM_CTRL_STARTON 4
`define SBM_CTRL_STOPON 5
`define SBM_CTRL_RAM64K 6
`define SBM_CTRL_AREAB 7
`define SBM_MODE_OFF 2'h0
`define SBM_MODE_WORD 2'h1
`define SBM_MODE_SEL 2'h2
`define SBM_MODE_RTMON 2'h3
`define SBM_WPTR_A 16'h0100
`define SBM_WPTR_B 16'h0104
`define SBM_CPTR_A 16'h0102
`define SBM_DPTR_A 16'h0103
`define SBM_CPTR_B 16'h0106
`define SBM_DPTR_B 16'h0107
`define SBM_LUT_HI 3'h5
`define SBM_TOP_64K 16'hffff
`define SBM_TOP_4K 16'h0fff
`define SBM_CMD_MASK_BASE 16'hff00
`define SBM_DAT_MASK_BASE 16'hfe00
`define SBM_BCAST_RT 5'h1f
`define SBM_SA_MODE0 5'h00
`define SBM_SA_MODE1 5'h1f
`define SBM_GAPLIM_RST 8'h14
`define SBM_DESC_LAST 2'h3
`define SBM_CLK_PERIOD_NS 4
`define SBM_GAP_UNIT_NS 1000
`define SBM_GAP_UNIT_CYC (`SBM_GAP_UNIT_NS / `SBM_CLK_PERIOD_NS)
`define SBM_GAP_MAX 8'hff
`endif

// ### hdl/sbm_gap_timer.sv
// Inter-word gap timer in microseconds, restarted by every received word
`include "sbm_defs.svh"
module sbm_gap_timer (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic word_seen,
    output logic [7:0] gap_us
);
    sbm_pkg::sbm_gap_s g_reg;
    sbm_pkg::sbm_gap_s g_next;

    always_comb begin
        g_next = g_reg;
        if (word_seen) begin
            g_next = '0;
        end else if (g_reg.div == 8'(`SBM_GAP_UNIT_CYC - 1)) begin
            g_next.div = 8'h00;
            if (g_reg.gap != `SBM_GAP_MAX) begin
                g_next.gap = g_reg.gap + 8'h01;
            end
        end else begin
            g_next.div = g_reg.div + 8'h01;
        end
        if (!resetn) begin
            g_next = '0;
        end
    end

    always_ff @(posedge mclk) begin
        g_reg <= g_next;
    end

    assign gap_us = g_reg.gap;
endmodule

// ### hdl/sbm_pkg.sv
// Types shared by the serial bus monitor modules
package sbm_pkg;
    typedef enum logic [12:0] {
        ST_IDLE   = 13'h0001,
        ST_W_PTR  = 13'h0002,
        ST_W_WAIT = 13'h0004,
        ST_W_WORD = 13'h0008,
        ST_W_TAG  = 13'h0010,
        ST_S_HUNT = 13'h0020,
        ST_S_LUT  = 13'h0040,
        ST_S_CPTR = 13'h0080,
        ST_S_DPTR = 13'h0100,
        ST_S_MSG  = 13'h0200,
        ST_S_DATA = 13'h0400,
        ST_S_DESC = 13'h0800,
        ST_S_PTRS = 13'h1000
    } sbm_state_e;

    typedef struct packed {
        sbm_state_e state;
        logic pend;
        logic [1:0] mode;
        logic trig_en;
        logic start_on;
        logic stop_on;
        logic ram64k;
        logic area_b;
        logic [15:0] trig_word;
        logic irq_mask;
        logic [4:0] own_rt;
        logic [1:0] cmd_size;
        logic [2:0] data_size;
        logic [7:0] gap_limit;
        logic [15:0] waddr;
        logic capturing;
        logic armed;
        logic overrun;
        logic have;
        logic [15:0] hold_word;
        logic [15:0] hold_tag;
        logic [15:0] cmd_word;
        logic [15:0] cptr;
        logic [15:0] dptr;
        logic [15:0] dstart;
        logic [5:0] remain;
        logic [5:0] stored;
        logic first;
        logic msg_err;
        logic [1:0] idx;
        logic ext_d;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } sbm_core_s;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic done;
        logic [15:0] rdata;
    } sbm_ram_s;

    typedef struct packed {
        logic [7:0] div;
        logic [7:0] gap;
    } sbm_gap_s;
endpackage

// ### hdl/sbm_ram_if.sv
// Request and completion signals between the monitor core and its RAM port
interface sbm_ram_if;
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    modport client(output req, output we, output addr, output wdata,
                   input rdata, input done);
    modport port(input req, input we, input addr, input wdata,
                 output rdata, output done);
endinterface

// ### hdl/sbm_ram_port.sv
// Shared RAM master: holds one request until the RAM acknowledges it
module sbm_ram_port (
    input wire logic mclk,
    input wire logic resetn,
    sbm_ram_if.port rif,
    output logic ram_req,
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [15:0] ram_wdata,
    input wire logic ram_ack,
    input wire logic [15:0] ram_rdata
);
    sbm_pkg::sbm_ram_s r_reg;
    sbm_pkg::sbm_ram_s r_next;

    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        if (r_reg.req && ram_ack) begin
            r_next.req = 1'b0;
            r_next.done = 1'b1;
            r_next.rdata = ram_rdata;
        end else if (!r_reg.req && rif.req) begin
            r_next.req = 1'b1;
            r_next.we = rif.we;
            r_next.addr = rif.addr;
            r_next.wdata = rif.wdata;
        end
        if (!resetn) begin
            r_next = '0;
        end
    end

    always_ff @(posedge mclk) begin
        r_reg <= r_next;
    end

    assign ram_req = r_reg.req;
    assign ram_we = r_reg.we;
    assign ram_addr = r_reg.addr;
    assign ram_wdata = r_reg.wdata;
    assign rif.done = r_reg.done;
    assign rif.rdata = r_reg.rdata;
endmodule

// ### hdl/sbm_top.sv
// Serial bus monitor core: word monitor, selective message monitor, APB registers
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`include "sbm_defs.svh"
module sbm_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [15:0] rx_word,
    input wire logic rx_chan,
    input wire logic rx_cmd_sync,
    input wire logic rx_err,
    input wire logic external_capture_trigger,
    output logic pattern_irq,
    output logic ram_req,
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [15:0] ram_wdata,
    input wire logic ram_ack,
    input wire logic [15:0] ram_rdata
);
    sbm_pkg::sbm_core_s r_reg;
    sbm_pkg::sbm_core_s r_next;
    logic [7:0] gap_us;

    sbm_ram_if rif ();

    sbm_ram_port u_ram (
        .mclk(mclk),
        .resetn(resetn),
        .rif(rif),
        .ram_req(ram_req),
        .ram_we(ram_we),
        .ram_addr(ram_addr),
        .ram_wdata(ram_wdata),
        .ram_ack(ram_ack),
        .ram_rdata(ram_rdata)
    );

    sbm_gap_timer u_gap (
        .mclk(mclk),
        .resetn(resetn),
        .word_seen(rx_valid),
        .gap_us(gap_us)
    );

    function automatic logic [15:0] wrap_inc(input logic [15:0] p, input logic [15:0] m);
        wrap_inc = (p & ~m) | ((p + 16'h0001) & m);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic wr_en;
    logic start_req;
    logic match;
    logic ext_rise;
    logic [15:0] top_mask;
    logic [15:0] cmask;
    logic [15:0] dmask;
    logic [4:0] rt_f;
    logic [4:0] sa_f;
    logic [4:0] wc_f;
    logic [5:0] n_words;
    logic [31:0] rdv;
    logic rd_ok;
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;

    always_comb begin
        r_next = r_reg;
        req = 1'b0;
        we = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        r_next.irq = 1'b0;
        top_mask = r_reg.ram64k ? `SBM_TOP_64K : `SBM_TOP_4K;
        cmask = ~(`SBM_CMD_MASK_BASE << {r_reg.cmd_size, 1'b0});
        dmask = ~(`SBM_DAT_MASK_BASE << r_reg.data_size);
        rt_f = r_reg.hold_word[15:11];
        sa_f = r_reg.hold_word[9:5];
        wc_f = r_reg.hold_word[4:0];
        if (sa_f == `SBM_SA_MODE0 || sa_f == `SBM_SA_MODE1) begin
            n_words = wc_f[4] ? 6'h02 : 6'h01;
        end else begin
            n_words = {(wc_f == 5'h00), wc_f} + 6'h01;
        end

        // APB slave: one wait state, write lands on the completing edge
        wr_en = psel && penable && r_reg.pready && pwrite;
        start_req = wr_en && paddr == `SBM_OFS_CTRL && pwdata[`SBM_CTRL_START];
        r_next.pready = psel && penable && !r_reg.pready;
        rd_ok = 1'b1;
        rdv = 32'h0000_0000;
        unique case (paddr)
            `SBM_OFS_CTRL: rdv = {24'h0, r_reg.area_b, r_reg.ram64k, r_reg.stop_on,
                                  r_reg.start_on, r_reg.trig_en, 1'b0, r_reg.mode};
            `SBM_OFS_TRIG: rdv = {16'h0, r_reg.trig_word};
            `SBM_OFS_MASK: rdv = {31'h0, r_reg.irq_mask};
            `SBM_OFS_OWNRT: rdv = {27'h0, r_reg.own_rt};
            `SBM_OFS_STKCFG: rdv = {27'h0, r_reg.data_size, r_reg.cmd_size};
            `SBM_OFS_GAPLIM: rdv = {24'h0, r_reg.gap_limit};
            `SBM_OFS_STKADDR: rdv = {16'h0, r_reg.waddr};
            `SBM_OFS_STATUS: rdv = {28'h0, !r_reg.state[0], r_reg.armed, r_reg.overrun,
                                    r_reg.capturing};
            default: rd_ok = 1'b0;
        endcase
        if (r_next.pready) begin
            r_next.prdata = pwrite ? 32'h0000_0000 : rdv;
            r_next.pslverr = !rd_ok;
        end
        if (wr_en) begin
            unique case (paddr)
                `SBM_OFS_CTRL: begin
                    if (pwdata[1:0] != r_reg.mode) begin
                        r_next.state = sbm_pkg::ST_IDLE;
                        r_next.pend = 1'b0;
                        r_next.capturing = 1'b0;
                        r_next.armed = 1'b0;
                        r_next.have = 1'b0;
                    end
                    r_next.mode = pwdata[1:0];
                    r_next.trig_en = pwdata[`SBM_CTRL_TRIGEN];
                    r_next.start_on = pwdata[`SBM_CTRL_STARTON];
                    r_next.stop_on = pwdata[`SBM_CTRL_STOPON];
                    r_next.ram64k = pwdata[`SBM_CTRL_RAM64K];
                    r_next.area_b = pwdata[`SBM_CTRL_AREAB];
                end
                `SBM_OFS_TRIG: r_next.trig_word = pwdata[15:0];
                `SBM_OFS_MASK: r_next.irq_mask = pwdata[0];
                `SBM_OFS_OWNRT: r_next.own_rt = pwdata[4:0];
                `SBM_OFS_STKCFG: begin
                    r_next.cmd_size = pwdata[1:0];
                    r_next.data_size = pwdata[4:2];
                end
                `SBM_OFS_GAPLIM: r_next.gap_limit = pwdata[7:0];
                `SBM_OFS_STATUS: if (pwdata[1]) r_next.overrun = 1'b0;
                default: ;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Word arrival, pattern match and external trigger
        match = rx_valid && rx_word == r_reg.trig_word;
        r_next.ext_d = external_capture_trigger;
        ext_rise = external_capture_trigger && !r_reg.ext_d;
        if (r_reg.mode == `SBM_MODE_WORD && !r_reg.state[0]) begin
            if (match) begin
                r_next.irq = r_reg.irq_mask;
            end
            if (r_reg.armed && (ext_rise || (match && r_reg.trig_en && r_reg.start_on))) begin
                r_next.armed = 1'b0;
                r_next.capturing = 1'b1;
            end
            if (match && r_reg.capturing && r_reg.trig_en && r_reg.stop_on) begin
                r_next.capturing = 1'b0;
            end
        end
        if (rx_valid && ((r_reg.mode == `SBM_MODE_WORD && (r_reg.capturing || r_next.capturing))
            || (r_reg.mode[1] && !r_reg.state[0]))) begin
            if (r_reg.have) begin
                r_next.overrun = 1'b1;
            end else begin
                r_next.have = 1'b1;
                r_next.hold_word = rx_word;
                r_next.hold_tag = {gap_us, 4'h0, (gap_us > r_reg.gap_limit), rx_chan,
                                   !rx_err, rx_cmd_sync};
            end
        end

        ////////////////////////////////////////////////////////////////////
        // Sequencer; each RAM access is issued once and waited for
        unique case (r_reg.state)
            sbm_pkg::ST_IDLE: begin
                if (r_next.mode == `SBM_MODE_WORD && start_req) begin
                    r_next.state = sbm_pkg::ST_W_PTR;
                end else if (r_reg.mode[1]) begin
                    r_next.state = sbm_pkg::ST_S_HUNT;
                end
            end
            sbm_pkg::ST_W_PTR: begin
                req = !r_reg.pend;
                addr = r_reg.area_b ? `SBM_WPTR_B : `SBM_WPTR_A;
                if (rif.done) begin
                    r_next.waddr = rif.rdata & top_mask;
                    r_next.armed = 1'b1;
                    r_next.capturing = !(r_reg.trig_en && r_reg.start_on);
                    r_next.state = sbm_pkg::ST_W_WAIT;
                end
            end
            sbm_pkg::ST_W_WAIT: begin
                if (r_reg.have) begin
                    r_next.state = sbm_pkg::ST_W_WORD;
                end
            end
            sbm_pkg::ST_W_WORD, sbm_pkg::ST_W_TAG: begin
                req = !r_reg.pend;
                we = 1'b1;
                addr = r_reg.waddr;
                wdata = r_reg.state[3] ? r_reg.hold_word : r_reg.hold_tag;
                if (rif.done) begin
                    r_next.waddr = (r_reg.waddr + 16'h0001) & top_mask;
                    if (r_reg.state[3]) begin
                        r_next.state = sbm_pkg::ST_W_TAG;
                    end else begin
                        r_next.have = 1'b0;
                        r_next.state = sbm_pkg::ST_W_WAIT;
                    end
                end
            end
            sbm_pkg::ST_S_HUNT: begin
                if (r_reg.have) begin
                    if (r_reg.hold_tag[0] && r_reg.hold_tag[1] && !(r_reg.mode ==
                        `SBM_MODE_RTMON && (rt_f == r_reg.own_rt || rt_f == `SBM_BCAST_RT))) begin
                        r_next.cmd_word = r_reg.hold_word;
                        r_next.state = sbm_pkg::ST_S_LUT;
                    end
                    r_next.have = 1'b0;
                end
            end
            sbm_pkg::ST_S_LUT: begin
                req = !r_reg.pend;
                addr = {6'h00, `SBM_LUT_HI, r_reg.cmd_word[15:11], r_reg.cmd_word[10],
                        r_reg.cmd_word[9]};
                if (rif.done) begin
                    r_next.state = rif.rdata[r_reg.cmd_word[8:5]] ? sbm_pkg::ST_S_CPTR
                                                                  : sbm_pkg::ST_S_HUNT;
                end
            end
            sbm_pkg::ST_S_CPTR, sbm_pkg::ST_S_DPTR: begin
                req = !r_reg.pend;
                addr = r_reg.state[7] ? (r_reg.area_b ? `SBM_CPTR_B : `SBM_CPTR_A)
                                      : (r_reg.area_b ? `SBM_DPTR_B : `SBM_DPTR_A);
                if (rif.done) begin
                    if (r_reg.state[7]) begin
                        r_next.cptr = rif.rdata;
                        r_next.state = sbm_pkg::ST_S_DPTR;
                    end else begin
                        r_next.dptr = rif.rdata;
                        r_next.dstart = rif.rdata;
                        r_next.stored = 6'h00;
                        r_next.first = 1'b1;
                        r_next.msg_err = 1'b0;
                        r_next.idx = 2'h0;
                        r_next.state = sbm_pkg::ST_S_MSG;
                    end
                end
            end
            sbm_pkg::ST_S_MSG: begin
                rt_f = r_reg.cmd_word[15:11];
                sa_f = r_reg.cmd_word[9:5];
                wc_f = r_reg.cmd_word[4:0];
                if (sa_f == `SBM_SA_MODE0 || sa_f == `SBM_SA_MODE1) begin
                    n_words = wc_f[4] ? 6'h02 : 6'h01;
                end else begin
                    n_words = {(wc_f == 5'h00), wc_f} + 6'h01;
                end
                if (r_reg.first) begin
                    r_next.remain = n_words;
                end
                if (r_reg.have) begin
                    // Sync words belong only in status or second-command slots
                    if (r_reg.hold_tag[0] && !(r_reg.first || r_reg.remain == 6'h01
                        || r_reg.remain == n_words + 6'h01)) begin
                        r_next.msg_err = 1'b1;
                        r_next.state = sbm_pkg::ST_S_DESC;
                    end else begin
                        if (r_reg.hold_tag[0] && r_reg.first && !r_reg.cmd_word[10]) begin
                            r_next.remain = n_words + 6'h02;
                        end
                        r_next.first = 1'b0;
                        r_next.state = sbm_pkg::ST_S_DATA;
                    end
                end else if (!r_reg.first && gap_us > r_reg.gap_limit) begin
                    r_next.msg_err = 1'b1;
                    r_next.state = sbm_pkg::ST_S_DESC;
                end
            end
            sbm_pkg::ST_S_DATA: begin
                req = !r_reg.pend;
                we = 1'b1;
                addr = r_reg.dptr;
                wdata = r_reg.hold_word;
                if (rif.done) begin
                    r_next.have = 1'b0;
                    r_next.dptr = wrap_inc(r_reg.dptr, dmask);
                    r_next.stored = r_reg.stored + 6'h01;
                    r_next.remain = r_reg.remain - 6'h01;
                    if (!r_reg.hold_tag[1]) begin
                        r_next.msg_err = 1'b1;
                    end
                    r_next.state = (r_reg.remain == 6'h01 || !r_reg.hold_tag[1])
                                   ? sbm_pkg::ST_S_DESC : sbm_pkg::ST_S_MSG;
                end
            end
            sbm_pkg::ST_S_DESC: begin
                req = !r_reg.pend;
                we = 1'b1;
                addr = r_reg.cptr;
                unique case (r_reg.idx)
                    2'h0: wdata = {r_reg.msg_err, 14'h0, r_reg.hold_tag[2]};
                    2'h1: wdata = r_reg.cmd_word;
                    2'h2: wdata = r_reg.dstart;
                    default: wdata = {10'h0, r_reg.stored};
                endcase
                if (rif.done) begin
                    r_next.cptr = wrap_inc(r_reg.cptr, cmask);
                    r_next.idx = r_reg.idx + 2'h1;
                    if (r_reg.idx == `SBM_DESC_LAST) begin
                        r_next.idx = 2'h0;
                        r_next.state = sbm_pkg::ST_S_PTRS;
                    end
                end
            end
            sbm_pkg::ST_S_PTRS: begin
                req = !r_reg.pend;
                we = 1'b1;
                addr = r_reg.idx[0] ? (r_reg.area_b ? `SBM_DPTR_B : `SBM_DPTR_A)
                                    : (r_reg.area_b ? `SBM_CPTR_B : `SBM_CPTR_A);
                wdata = r_reg.idx[0] ? r_reg.dptr : r_reg.cptr;
                if (rif.done) begin
                    r_next.idx = r_reg.idx + 2'h1;
                    if (r_reg.idx[0]) begin
                        r_next.idx = 2'h0;
                        r_next.state = sbm_pkg::ST_S_HUNT;
                    end
                end
            end
            default: r_next.state = sbm_pkg::ST_IDLE;
        endcase
        if (req) begin
            r_next.pend = 1'b1;
        end
        if (rif.done) begin
            r_next.pend = 1'b0;
        end

        if (!resetn) begin
            r_next = '0;
            r_next.state = sbm_pkg::ST_IDLE;
            r_next.gap_limit = `SBM_GAPLIM_RST;
            r_next.ram64k = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        r_reg <= r_next;
    end

    assign rif.req = req && resetn;
    assign rif.we = we;
    assign rif.addr = addr;
    assign rif.wdata = wdata;
    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign pattern_irq = r_reg.irq;
endmodule

// ### tb/sbm_ram_model.sv
// Shared RAM partner that answers the monitor's requests
module sbm_ram_model (
    input wire logic mclk,
    input wire logic slow,
    input wire logic ram_req,
    input wire logic ram_we,
    input wire logic [15:0] ram_addr,
    input wire logic [15:0] ram_wdata,
    output logic ram_ack,
    output logic [15:0] ram_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:65535];
    logic [2:0] cnt = 3'h0;
    initial begin
        ram_ack = 1'b0;
        ram_rdata = 16'h0;
        foreach (mem[i]) mem[i] = 16'h0;
    end
    always @(posedge mclk) begin
        ram_ack <= 1'b0;
        // Read data is only good with the acknowledge
        ram_rdata <= ~ram_rdata;
        if (ram_req && !ram_ack) begin
            if (cnt >= (slow ? 3'h4 : 3'h0)) begin
                ram_ack <= 1'b1;
                cnt <= 3'h0;
                if (ram_we) mem[ram_addr] <= ram_wdata;
                else ram_rdata <= mem[ram_addr];
            end else cnt <= cnt + 3'h1;
        end
    end
endmodule

// ### tb/sbm_top_chk.sv
// Port assertions for the serial bus monitor
module sbm_top_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pattern_irq,
    input wire logic ram_req,
    input wire logic ram_we,
    input wire logic [15:0] ram_addr,
    input wire logic [15:0] ram_wdata,
    input wire logic ram_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no answer");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("long answer");
    property p_err; pready && pslverr |-> prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("refused data");
    property p_hold;
        ram_req && !ram_ack |=> ram_req && $stable(ram_addr) && $stable(ram_wdata)
            && $stable(ram_we);
    endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    property p_drop; ram_ack |=> !ram_req; endproperty
    a_drop: assert property (p_drop) else $error("request kept");
    property p_wrap;
        ram_ack && ram_we && ram_addr == 16'hffff |=> !ram_req ##2
            (!ram_req || ram_addr == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_rdloc;
        ram_req && !ram_we |-> ram_addr[15:7] == 9'h005 || ram_addr inside
            {16'h0100, 16'h0104, 16'h0102, 16'h0103, 16'h0106, 16'h0107};
    endproperty
    a_rdloc: assert property (p_rdloc) else $error("bad read");
    property p_irq; pattern_irq |=> !pattern_irq; endproperty
    a_irq: assert property (p_irq) else $error("irq stuck");
endmodule
bind sbm_top sbm_top_chk u_chk (.*);

// ### tb/sbm_top_tb.sv
// Self-checking bench of the serial bus monitor
`define CK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module sbm_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, e;
    logic rx_valid = 0, rx_chan = 0, rx_cmd_sync = 0, rx_err = 0;
    logic external_capture_trigger = 0, pready, pslverr, pattern_irq;
    logic ram_req, ram_we, ram_ack;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [15:0] rx_word = 0, ram_addr, ram_wdata, ram_rdata;
    int errors = 0, n_compared = 0, irqs = 0;
    sbm_top dut (.*);
    sbm_ram_model m (.*);
    always #2 mclk = ~mclk;
    always @(posedge mclk) if (pattern_irq === 1'b1) irqs++;
    task end_of_test;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task sw(input logic [15:0] w, input logic c, s, x);
        repeat (40) @(posedge mclk);
        rx_valid <= 1; rx_word <= w; rx_chan <= c; rx_cmd_sync <= s; rx_err <= x;
        @(posedge mclk);
        rx_valid <= 0; rx_word <= ~w;
        repeat (40) @(posedge mclk);
    endtask
    task t_regs;
        apb(0, 8'h14, 0); `CK(r, 32'h14)
        apb(0, 8'h00, 0); `CK(r, 32'h40)
        apb(1, 8'h24, 32'h5); `CK(e, 1'b1)
    endtask
    task t_word;
        m.mem[16'h0100] = 16'hffff;
        apb(1, 8'h08, 1); apb(1, 8'h04, 32'h1234); apb(1, 8'h00, 32'h45);
        sw(16'h1234, 1, 1, 0); sw(16'h5555, 0, 0, 1);
        `CK(m.mem[16'hffff], 16'h1234)
        `CK(m.mem[16'h0000][2:0], 3'h7)
        `CK(m.mem[16'h0001], 16'h5555)
        `CK(m.mem[16'h0002][2:0], 3'h0)
        apb(0, 8'h18, 0); `CK(r, 32'h3)
        `CK(irqs, 1)
    endtask
    task t_ext;
        apb(1, 8'h00, 0);
        m.mem[16'h0100] = 16'h0200;
        apb(1, 8'h00, 32'h5d);
        repeat (10) @(posedge mclk);
        apb(0, 8'h1c, 0); `CK(r[2], 1'b1)
        sw(16'h7777, 0, 0, 0);
        apb(0, 8'h18, 0); `CK(r, 32'h200)
        external_capture_trigger <= 1;
        sw(16'h8888, 0, 0, 0);
        `CK(m.mem[16'h0200], 16'h8888)
        apb(1, 8'h04, 32'h9999); apb(1, 8'h00, 32'h69);
        sw(16'h9999, 0, 0, 0); sw(16'haaaa, 0, 0, 0);
        apb(0, 8'h18, 0); `CK(r, 32'h204)
    endtask
    task t_sel;
        apb(1, 8'h00, 0);
        m.mem[16'h0102] = 16'h0400; m.mem[16'h0103] = 16'h0800;
        m.mem[16'h0294] = 16'h0004;
        apb(1, 8'h00, 32'h42);
        sw(16'h2841, 0, 1, 0); sw(16'haaaa, 0, 0, 0); sw(16'h2800, 0, 1, 0);
        `CK(m.mem[16'h0800], 16'haaaa)
        `CK(m.mem[16'h0801], 16'h2800)
        `CK(m.mem[16'h0401], 16'h2841)
        `CK(m.mem[16'h0403], 16'h0002)
        `CK(m.mem[16'h0102], 16'h0404)
        sw(16'h2861, 0, 1, 0); sw(16'haaaa, 0, 0, 0); sw(16'h2800, 0, 1, 0);
        `CK(m.mem[16'h0102], 16'h0404)
        apb(1, 8'h0c, 32'h5); apb(1, 8'h00, 32'h43);
        sw(16'h2841, 0, 1, 0); sw(16'haaaa, 0, 0, 0); sw(16'h2800, 0, 1, 0);
        `CK(m.mem[16'h0102], 16'h0404)
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1;
        t_regs;
        slow <= 1;
        t_word;
        slow <= 0;
        t_ext;
        t_sel;
        end_of_test;
    end
    initial begin
        #100000;
        errors++;
        end_of_test;
    end
endmodule
